// ---- rtl/spi_flash_decoder.sv ----
// Purpose: instruction decoder and bank address logic of the flash end
// Assumes: mode 0 link, sck far slower than mclk (>= 8 mclk per half)
// Notes:   dummy cycles and multi-lane data are outside this block
// Summary of operation
// - decode DDR reads 0D, BD, ED
// - decode program 02, 32 and erase 20, D8
// - 3-byte address is offset inside bank
// - host writes bank before reaching upper banks
// - bank applies to read, program, erase
// - bank register gives top address byte
// - bank register volatile, resets to bank zero
// - reads stream on across banks without delay
// - bank used at start only, never updated
// - bank 00 at 0, 01 at 01000000
// - identity ops 90, 9F, AB; AB slow
// - register ops 05 07 35 01 04 06 30
// - bank read 16, write 17, B9 access
// - learning ops 41, 43, 4A
// - plain read 03 and 13, slow clock
// - fast read 0B and 0C
// - DDR fast read 0D and 0E
// - dual out 3B/3C, quad out 6B/6C
// - dual I/O BB/BC, DDR dual BD
// - wide bit set means 32-bit address
// - bytes and bits most significant first
//
// The AXI4-Lite register port and the address map were decided locally.
`include "spi_flash_map.svh"
module spi_flash_decoder (
  input  wire logic        mclk,
  input  wire logic        resetn,
  spi_link_if.flash        link,
  output logic             cmdValid,
  output logic [7:0]       cmdCode,
  output logic [31:0]      cmdAddr,
  output logic [31:0]      dataAddr,
  input  wire logic [7:0]  dataIn,
  output logic             wrValid,
  output logic [7:0]       wrByte,
  output logic [7:0]       bankSel,
  output logic             cmdEnd
);
  // ======================================================
  // opcode table
  function automatic spi_flash_pkg::op_info_t decodeOp(
    input logic [7:0] code);
    spi_flash_pkg::op_info_t r;
    r = spi_flash_pkg::INFO_NONE;
    unique case (code)
      `OP_DDR_FAST_READ,
      `OP_DDR_DUAL_IO_READ,
      `OP_DDR_QUAD_IO_READ,
      `OP_PLAIN_READ,
      `OP_FAST_READ,
      `OP_DUAL_OUT_READ, `OP_QUAD_OUT_READ,
      `OP_DUAL_IO_READ: r = spi_flash_pkg::INFO_RD;
      `OP_PLAIN_READ_WIDE,
      `OP_FAST_READ_WIDE,
      `OP_DDR_FAST_WIDE,
      `OP_DUAL_OUT_WIDE, `OP_QUAD_OUT_WIDE,
      `OP_DUAL_IO_WIDE: r = spi_flash_pkg::INFO_RDW;
      `OP_PAGE_PROGRAM,
      `OP_QUAD_PAGE_PROGRAM: r = spi_flash_pkg::INFO_PROG;
      `OP_SMALL_ERASE,
      `OP_LARGE_ERASE: r = spi_flash_pkg::INFO_ERAS;
      `OP_MAKER_SIG_READ, `OP_IDENTITY_READ,
      `OP_SIGNATURE_READ: r = spi_flash_pkg::INFO_OUT;
      `OP_STATUS_ONE_READ, `OP_STATUS_TWO_READ,
      `OP_CONFIG_READ: r = spi_flash_pkg::INFO_OUT;
      `OP_STATUS_CFG_WRITE: r = spi_flash_pkg::INFO_IN;
      `OP_WRITE_DISABLE, `OP_WRITE_ENABLE,
      `OP_FAIL_CLEAR: r = spi_flash_pkg::INFO_BARE;
      `OP_BANK_READ: r = spi_flash_pkg::INFO_OUT;
      `OP_BANK_WRITE,
      `OP_BANK_ACCESS: r = spi_flash_pkg::INFO_IN;
      `OP_LEARN_READ: r = spi_flash_pkg::INFO_OUT;
      `OP_LEARN_NV_PROGRAM,
      `OP_LEARN_VOL_WRITE: r = spi_flash_pkg::INFO_IN;
      default: r = spi_flash_pkg::INFO_NONE;
    endcase
    return r;
  endfunction

  // ======================================================
  // pin synchronisers and edge detect
  logic [1:0] sckS;
  logic [1:0] csS;
  logic [1:0] mosiS;
  logic       sckD;
  logic       csD;

  // link pins come from another domain: two flops each
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sckS  <= 2'h0;
      csS   <= 2'h3;
      mosiS <= 2'h0;
      sckD  <= 1'b0;
      csD   <= 1'b1;
    end else begin
      sckS  <= {sckS[0], link.sck};
      csS   <= {csS[0], link.csN};
      mosiS <= {mosiS[0], link.mosi};
      sckD  <= sckS[1];
      csD   <= csS[1];
    end
  end

  wire sckRise = sckS[1] & ~sckD;
  wire sckFall = ~sckS[1] & sckD;
  wire csHigh  = csS[1];
  wire csRise  = csS[1] & ~csD;

  // ======================================================
  // state and byte assembly
  spi_flash_pkg::dev_state_t state;
  spi_flash_pkg::dev_state_t next_state;
  spi_flash_pkg::op_info_t   info;
  logic [7:0]  inSh;
  logic [2:0]  bitCnt;
  logic [23:0] addrSh;
  logic [2:0]  addrLeft;
  logic [7:0]  outSh;
  logic [2:0]  outCnt;
  logic        misoReg;
  logic        firstIn;
  logic [31:0] curAddr;

  // bits arrive most significant first, byte after byte
  wire [7:0] inByte   = {inSh[6:0], mosiS[1]};
  wire       byteDone = sckRise & (bitCnt == 3'h7);
  wire spi_flash_pkg::op_info_t opInfo = decodeOp(inByte);
  wire       wideMode = bankSel[`BANK_WIDE_BIT];
  wire       lastAddr = (addrLeft == 3'h1);
  wire [31:0] fullAddr = {addrSh, inByte};
  // 3-byte form is an offset in the selected bank
  wire [31:0] startAddr = (info.wideOnly | wideMode) ? fullAddr
    : {1'b0, bankSel[`BANK_NUM_F], fullAddr[`LOW_ADDR_F]};
  wire [2:0] addrBytes = (opInfo.wideOnly | wideMode)
    ? `ADDR_WIDE_BYTES : `ADDR_STD_BYTES;
  wire isBankRd = (cmdCode == `OP_BANK_READ);
  wire isBankWr = (cmdCode == `OP_BANK_WRITE) |
                  (cmdCode == `OP_BANK_ACCESS);
  wire [7:0] outByte = isBankRd ? bankSel : dataIn;

  // phase selection after the byte that ends a phase
  wire spi_flash_pkg::dev_state_t afterOpc =
    !opInfo.known  ? spi_flash_pkg::D_IGN :
    opInfo.hasAddr ? spi_flash_pkg::D_ADDR :
    opInfo.dataOut ? spi_flash_pkg::D_OUT :
    opInfo.dataIn  ? spi_flash_pkg::D_IN : spi_flash_pkg::D_IGN;
  wire spi_flash_pkg::dev_state_t afterAddr =
    info.dataOut ? spi_flash_pkg::D_OUT :
    info.dataIn  ? spi_flash_pkg::D_IN : spi_flash_pkg::D_IGN;
  assign next_state =
    (state == spi_flash_pkg::D_OPC) ? afterOpc :
    (state == spi_flash_pkg::D_ADDR && lastAddr) ? afterAddr : state;

  // deselect always returns to opcode phase
  always_ff @(posedge mclk) begin
    if (!resetn || csHigh)
      state <= spi_flash_pkg::D_OPC;
    else if (byteDone)
      state <= next_state;
  end

  // bit counter and input shifter
  always_ff @(posedge mclk) begin
    if (!resetn || csHigh) begin
      bitCnt <= 3'h0;
      inSh   <= 8'h00;
    end else if (sckRise) begin
      bitCnt <= bitCnt + 3'h1;
      inSh   <= inByte;
    end
  end

  // ======================================================
  // opcode latch and address collection
  wire takeOpc  = byteDone && state == spi_flash_pkg::D_OPC;
  wire takeAddr = byteDone && state == spi_flash_pkg::D_ADDR;
  wire takeData = byteDone && state == spi_flash_pkg::D_IN;
  wire issueNow = (takeOpc && opInfo.known && !opInfo.hasAddr) ||
                  (takeAddr && lastAddr);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      info     <= spi_flash_pkg::INFO_NONE;
      cmdCode  <= 8'h00;
      addrLeft <= 3'h0;
      addrSh   <= 24'h000000;
    end else if (takeOpc) begin
      info     <= opInfo;
      cmdCode  <= inByte;
      addrLeft <= addrBytes;
      addrSh   <= 24'h000000;
    end else if (takeAddr) begin
      addrSh   <= fullAddr[`LOW_ADDR_F];
      addrLeft <= addrLeft - 3'h1;
    end
  end

  // command report; unknown codes never raise it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmdValid <= 1'b0;
      cmdAddr  <= 32'h00000000;
    end else begin
      cmdValid <= issueNow;
      if (takeAddr && lastAddr)
        cmdAddr <= startAddr;
      else if (issueNow)
        cmdAddr <= 32'h00000000;
    end
  end

  // ======================================================
  // running address: bank feeds only the start
  always_ff @(posedge mclk) begin
    if (!resetn)
      curAddr <= 32'h00000000;
    else if (takeAddr && lastAddr)
      curAddr <= startAddr;
    else if (issueNow)
      curAddr <= 32'h00000000;
    else if (takeData ||
             (sckFall && state == spi_flash_pkg::D_OUT &&
              outCnt == 3'h0))
      curAddr <= curAddr + 32'h00000001;   // no bank wrap, no stall
  end
  assign dataAddr = curAddr;

  // ======================================================
  // write data and bank register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wrValid <= 1'b0;
      wrByte  <= 8'h00;
      firstIn <= 1'b0;
    end else begin
      wrValid <= takeData;
      if (takeData)
        wrByte <= inByte;
      if (issueNow)
        firstIn <= 1'b1;
      else if (takeData)
        firstIn <= 1'b0;
    end
  end

  // only the first data byte of a bank write lands;
  // streaming never touches it
  always_ff @(posedge mclk) begin
    if (!resetn)
      bankSel <= `BANK_RESET;
    else if (takeData && firstIn && isBankWr)
      bankSel <= inByte;
  end

  // ======================================================
  // read data out, changed on falling sck
  always_ff @(posedge mclk) begin
    if (!resetn || csHigh) begin
      outCnt  <= 3'h0;
      outSh   <= 8'h00;
      misoReg <= 1'b0;
    end else if (sckFall && state == spi_flash_pkg::D_OUT) begin
      outCnt <= outCnt + 3'h1;
      if (outCnt == 3'h0) begin
        misoReg <= outByte[7];
        outSh   <= {outByte[6:0], 1'b0};
      end else begin
        misoReg <= outSh[7];
        outSh   <= {outSh[6:0], 1'b0};
      end
    end
  end
  assign link.miso = misoReg;

  // end of frame marker for the array side
  always_ff @(posedge mclk) begin
    if (!resetn)
      cmdEnd <= 1'b0;
    else
      cmdEnd <= csRise;
  end
endmodule // spi_flash_decoder

// ---- pkg/spi_flash_map.svh ----
// Purpose: opcode values, register offsets and fields for the flash link
// Assumes: included by bare name wherever a value is needed
// Notes:   host offsets are byte addresses on the AXI4-Lite bus
`ifndef SPI_FLASH_MAP_SVH
`define SPI_FLASH_MAP_SVH
// ======================================================
// array reads
`define OP_PLAIN_READ        8'h03
`define OP_PLAIN_READ_WIDE   8'h13
`define OP_FAST_READ         8'h0B
`define OP_FAST_READ_WIDE    8'h0C
`define OP_DDR_FAST_READ     8'h0D
`define OP_DDR_FAST_WIDE     8'h0E
`define OP_DUAL_OUT_READ     8'h3B
`define OP_DUAL_OUT_WIDE     8'h3C
`define OP_QUAD_OUT_READ     8'h6B
`define OP_QUAD_OUT_WIDE     8'h6C
`define OP_DUAL_IO_READ      8'hBB
`define OP_DUAL_IO_WIDE      8'hBC
`define OP_DDR_DUAL_IO_READ  8'hBD
`define OP_DDR_QUAD_IO_READ  8'hED
// ======================================================
// program and erase
`define OP_PAGE_PROGRAM      8'h02
`define OP_QUAD_PAGE_PROGRAM 8'h32
`define OP_SMALL_ERASE       8'h20
`define OP_LARGE_ERASE       8'hD8
// ======================================================
// identification and registers
`define OP_MAKER_SIG_READ    8'h90
`define OP_IDENTITY_READ     8'h9F
`define OP_SIGNATURE_READ    8'hAB
`define OP_STATUS_ONE_READ   8'h05
`define OP_STATUS_TWO_READ   8'h07
`define OP_CONFIG_READ       8'h35
`define OP_STATUS_CFG_WRITE  8'h01
`define OP_WRITE_DISABLE     8'h04
`define OP_WRITE_ENABLE      8'h06
`define OP_FAIL_CLEAR        8'h30
`define OP_BANK_READ         8'h16
`define OP_BANK_WRITE        8'h17
`define OP_BANK_ACCESS       8'hB9
`define OP_LEARN_READ        8'h41
`define OP_LEARN_NV_PROGRAM  8'h43
`define OP_LEARN_VOL_WRITE   8'h4A
// ======================================================
// bank register layout
`define BANK_RESET           8'h00
`define BANK_WIDE_BIT        7
`define BANK_NUM_F           6:0
`define ADDR_STD_BYTES       3'h3
`define ADDR_WIDE_BYTES      3'h4
`define LOW_ADDR_F           23:0
// ======================================================
// host controller registers
`define REG_CMD              8'h00
`define REG_ADDR             8'h04
`define REG_TXD              8'h08
`define REG_RXD              8'h0C
`define REG_STAT             8'h10
`define CMD_OP_F             7:0
`define CMD_ALEN_F           10:8
`define CMD_DLEN_F           13:11
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

// ---- pkg/spi_flash_pkg.sv ----
// Purpose: shared types of the flash link ends
// Assumes: nothing
// Notes:   opcode values live in spi_flash_map.svh
package spi_flash_pkg;
  // ======================================================
  // opcode class
  typedef struct packed {
    logic known;
    logic hasAddr;
    logic wideOnly;
    logic dataOut;
    logic dataIn;
  } op_info_t;
  localparam op_info_t INFO_NONE = 5'h00;
  localparam op_info_t INFO_RD   = 5'h1A;
  localparam op_info_t INFO_RDW  = 5'h1E;
  localparam op_info_t INFO_PROG = 5'h19;
  localparam op_info_t INFO_ERAS = 5'h18;
  localparam op_info_t INFO_OUT  = 5'h12;
  localparam op_info_t INFO_IN   = 5'h11;
  localparam op_info_t INFO_BARE = 5'h10;
  // ======================================================
  // states
  typedef enum logic [4:0] {
    D_OPC  = 5'h01,
    D_ADDR = 5'h02,
    D_IN   = 5'h04,
    D_OUT  = 5'h08,
    D_IGN  = 5'h10
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_RUN  = 3'h2,
    H_END  = 3'h4
  } host_state_t;
endpackage

// ---- pkg/spi_link_if.sv ----
// Purpose: serial link between controller and flash decoder
// Assumes: single-bit lanes, mode 0 clocking
// Notes:   no clocking block; both ends sample on their own clock
interface spi_link_if;
  logic sck;
  logic csN;
  logic mosi;
  logic miso;
  modport flash (input sck, input csN, input mosi, output miso);
  modport ctrl  (output sck, output csN, output mosi, input miso);
endinterface

// ---- rtl/spi_flash_host.sv ----
// Purpose: link controller driven from AXI4-Lite registers
// Assumes: one frame at a time, mode 0, single-bit lanes
// Notes:   sck is mclk divided by 2*HALF; rates stay far below limits
`include "spi_flash_map.svh"
module spi_flash_host #(
  parameter int HALF = 8
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  spi_link_if.ctrl         link
);
  // ======================================================
  // bus slave
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  wAddr;
  logic [31:0] wWord;
  logic [13:0] cmdWord;
  logic [31:0] addrReg;
  logic [31:0] txReg;
  logic [31:0] rxReg;
  spi_flash_pkg::host_state_t state;

  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;
  wire busy    = (state != spi_flash_pkg::H_IDLE);
  wire doWrite = awHeld && wHeld && !bvalid;
  wire wMapped = (wAddr == `REG_CMD) || (wAddr == `REG_ADDR) ||
                 (wAddr == `REG_TXD);
  // a command write while busy is dropped, not queued
  wire start   = doWrite && wAddr == `REG_CMD && !busy;

  // address and data taken in either order
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      wAddr  <= 8'h00;
      wWord  <= 32'h00000000;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        wAddr  <= awaddr;
      end else if (doWrite)
        awHeld <= 1'b0;
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wWord <= wdata;
      end else if (doWrite)
        wHeld <= 1'b0;
    end
  end

  // register update and write answer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      cmdWord <= 14'h0000;
      addrReg <= 32'h00000000;
      txReg   <= 32'h00000000;
    end else begin
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= wMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready)
        bvalid <= 1'b0;
      if (start)
        cmdWord <= wWord[13:0];
      if (doWrite && wAddr == `REG_ADDR)
        addrReg <= wWord;
      if (doWrite && wAddr == `REG_TXD)
        txReg <= wWord;
    end
  end

  // read answer one cycle after address
  wire [31:0] rdMux =
    (araddr == `REG_CMD)  ? {18'h00000, cmdWord} :
    (araddr == `REG_ADDR) ? addrReg :
    (araddr == `REG_TXD)  ? txReg :
    (araddr == `REG_RXD)  ? rxReg :
    (araddr == `REG_STAT) ? {31'h00000000, busy} : 32'h00000000;
  wire rMapped = (araddr == `REG_CMD) || (araddr == `REG_ADDR) ||
    (araddr == `REG_TXD) || (araddr == `REG_RXD) ||
    (araddr == `REG_STAT);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= rMapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready)
      rvalid <= 1'b0;
  end

  // ======================================================
  // frame engine
  logic [1:0]  misoS;
  logic [71:0] sh;
  logic [6:0]  bitsLeft;
  logic [15:0] divCnt;
  logic        sckReg;
  logic        csReg;

  wire [2:0] aLen = wWord[`CMD_ALEN_F];
  wire [2:0] dLen = wWord[`CMD_DLEN_F];
  // address bytes sit just after the opcode, data right behind
  wire [63:0] body = {addrReg, txReg} << {3'h4 - aLen, 3'h0};
  wire [3:0]  nBytes = {1'b0, aLen} + {1'b0, dLen} + 4'h1;
  wire        tick = (divCnt == 16'(HALF - 1));

  // miso crosses in through two flops
  always_ff @(posedge mclk) begin
    if (!resetn)
      misoS <= 2'h0;
    else
      misoS <= {misoS[0], link.miso};
  end

  // software issues 17 first to reach upper banks
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state    <= spi_flash_pkg::H_IDLE;
      divCnt   <= 16'h0000;
      sckReg   <= 1'b0;
      csReg    <= 1'b1;
      sh       <= 72'h0;
      bitsLeft <= 7'h00;
      rxReg    <= 32'h00000000;
    end else begin
      divCnt <= (tick || !busy) ? 16'h0000 : divCnt + 16'h0001;
      unique case (state)
        spi_flash_pkg::H_IDLE: if (start) begin
          state    <= spi_flash_pkg::H_RUN;
          csReg    <= 1'b0;
          sh       <= {wWord[`CMD_OP_F], body};
          bitsLeft <= {nBytes, 3'h0};
        end
        // half period per phase keeps every rate limit
        spi_flash_pkg::H_RUN: if (tick) begin
          sckReg <= !sckReg;
          if (!sckReg)
            rxReg <= {rxReg[30:0], misoS[1]};
          else begin
            sh       <= {sh[70:0], 1'b0};
            bitsLeft <= bitsLeft - 7'h01;
            if (bitsLeft == 7'h01)
              state <= spi_flash_pkg::H_END;
          end
        end
        spi_flash_pkg::H_END: if (tick) begin
          csReg <= 1'b1;
          state <= spi_flash_pkg::H_IDLE;
        end
      endcase
    end
  end
  assign link.sck  = sckReg;
  assign link.csN  = csReg;
  assign link.mosi = sh[71];
endmodule // spi_flash_host

// ---- bench/spi_flash_sva.sv ----
// Purpose: link-level checks between host and flash decoder
// Assumes: HALF = 8, so each sck half lasts 8 mclk
// Notes:   sees only interface wires plus clock and reset
module spi_flash_sva (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================
  // clocking and sck phases
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence hiHalf;
    sck [*8];
  endsequence
  sequence loHalf;
    !sck [*8];
  endsequence
  // mode 0: clock parks low, data moves only while clock is low
  idle_low_a: assert property (csN |-> !sck)
    else $error("sck active while deselected");
  cs_edge_a: assert property ($changed(csN) |-> !sck)
    else $error("csN moved with sck high");
  cs_lead_a: assert property ($fell(csN) |-> loHalf)
    else $error("first sck rise too early");
  hi_half_a: assert property ($rose(sck) |-> hiHalf ##1 !sck)
    else $error("sck high phase not 8 cycles");
  lo_half_a: assert property ($fell(sck) |-> loHalf)
    else $error("sck low phase short");
  mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  miso_hold_a: assert property (sck |-> $stable(miso))
    else $error("miso moved while sck high");
  miso_idle_a: assert property (csN [*8] |-> !miso)
    else $error("miso not parked low");
endmodule // spi_flash_sva

// ---- bench/tb.sv ----
// Purpose: host and decoder joined on one link, driven over AXI4-Lite
// Assumes: array side answers dataIn = addr[7:0] ^ addr[31:24]
// Notes:   wstrb tied to full words, the host ignores it anyway
`include "spi_flash_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================================
  // signals and instances
  logic        mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cmdValid, wrValid, cmdEnd;
  logic [7:0]  awaddr, araddr, cmdCode, wrByte, bankSel, dataIn;
  logic [7:0]  lastCode, lastWr;
  logic [31:0] wdata, rdata, cmdAddr, dataAddr, lastAddr, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb;
  int          fails, samples_checked, nCmd, nWr, nEnd;
  localparam logic [7:0] OPS [34] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h0D,
    8'h0E, 8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hBD, 8'hED, 8'h02,
    8'h32, 8'h20, 8'hD8, 8'h90, 8'h9F, 8'hAB, 8'h05, 8'h07, 8'h35, 8'h01,
    8'h04, 8'h06, 8'h30, 8'h16, 8'h17, 8'hB9, 8'h41, 8'h43, 8'h4A};
  spi_link_if link ();
  spi_flash_host #(.HALF(8)) spi_flash_host_inst (.mclk(mclk),
    .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link(link));
  spi_flash_decoder spi_flash_decoder_inst (.mclk(mclk), .resetn(resetn),
    .link(link), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
    .dataAddr(dataAddr), .dataIn(dataIn), .wrValid(wrValid),
    .wrByte(wrByte), .bankSel(bankSel), .cmdEnd(cmdEnd));
  spi_flash_sva spi_flash_sva_inst (.mclk(mclk), .resetn(resetn),
    .sck(link.sck), .csN(link.csN), .mosi(link.mosi), .miso(link.miso));
  // array model: byte depends on low and top address bytes
  assign dataIn = dataAddr[7:0] ^ dataAddr[31:24];
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // record what the decoder reports to the array side
  always @(posedge mclk) begin
    if (cmdValid === 1'b1) begin
      nCmd <= nCmd + 1;
      lastCode <= cmdCode;
      lastAddr <= cmdAddr;
    end
    if (wrValid === 1'b1) begin
      nWr <= nWr + 1;
      lastWr <= wrByte;
    end
    if (cmdEnd === 1'b1) nEnd <= nEnd + 1;
  end
  // ====================================
  // helpers
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ck(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic hang;
    ck(1'b0, "timeout");
    print_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 99) hang();
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 99) hang();
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // one whole frame; returns once the decoder has seen deselect
  task automatic frame(input logic [7:0] op, input logic [2:0] al,
      input logic [2:0] dl, input logic [31:0] ad, input logic [31:0] tx);
    int n;
    int e0;
    e0 = nEnd;
    wr(`REG_ADDR, ad);
    wr(`REG_TXD, tx);
    wr(`REG_CMD, {18'h0, dl, al, op});
    for (n = 0; n < 999; n++) begin
      rdr(`REG_STAT);
      if (rd[0] === 1'b0 && nEnd != e0) break;
    end
    if (n == 999) hang();
  endtask
  // ====================================
  // scenarios
  task automatic t_reset;
    ck(bankSel === 8'h00, "bank not zero");
    rdr(8'h20);
    ck(rs === `RESP_SLVERR && rd === 32'h0, "unmapped read");
  endtask
  task automatic t_ops;
    logic [2:0] al;
    int c0;
    foreach (OPS[i]) begin
      al = (OPS[i] inside {8'h13, 8'h0C, 8'h0E, 8'h3C, 8'h6C, 8'hBC}) ? 3'h4
         : (i < 18) ? 3'h3 : 3'h0;
      c0 = nCmd;
      frame(OPS[i], al, (i == 16 || i == 17) ? 3'h0 : 3'h1, 32'h100, 0);
      ck(nCmd == c0 + 1 && lastCode === OPS[i], "opcode");
    end // also
  endtask
  task automatic t_unknown;
    logic [7:0] bad [3] = '{8'h18, 8'hA3, 8'h60};
    int c0;
    int w0;
    foreach (bad[i]) begin
      c0 = nCmd;
      w0 = nWr;
      frame(bad[i], 3'h0, 3'h2, 32'h0, 32'hFFFFFFFF);
      ck(nCmd == c0 && nWr == w0 && bankSel === 8'h00, "unknown op");
    end
  endtask
  task automatic t_bank;
    int w0;
    frame(8'h17, 3'h0, 3'h1, 32'h0, 32'h01000000);
    ck(bankSel === 8'h01, "bank write");
    frame(8'h16, 3'h0, 3'h1, 32'h0, 32'h0);
    rdr(`REG_RXD);
    ck(rd[7:0] === 8'h01, "bank read");
    frame(8'h03, 3'h3, 3'h2, 32'h00FFFFFF, 32'h0);
    ck(lastAddr === 32'h01FFFFFF, "banked addr");
    rdr(`REG_RXD);
    ck(rd[15:0] === 16'hFE02, "stream across bank");
    ck(bankSel === 8'h01, "bank moved");
    w0 = nWr;
    frame(8'h02, 3'h3, 3'h1, 32'h10, 32'h5A000000);
    ck(lastAddr === 32'h01000010 && nWr == w0 + 1, "program");
    ck(lastWr === 8'h5A, "program byte");
    frame(8'hB9, 3'h0, 3'h1, 32'h0, 32'h80000000);
    ck(bankSel === 8'h80, "bank access");
    frame(8'h03, 3'h4, 3'h1, 32'h12345678, 32'h0);
    ck(lastAddr === 32'h12345678, "wide addr");
    frame(8'h17, 3'h0, 3'h1, 32'h0, 32'h01000000);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    ck(bankSel === 8'h00, "bank after reset");
  endtask
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    {fails, samples_checked, nCmd, nWr, nEnd} = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_ops();
    t_unknown();
    t_bank();
    print_verdict();
  end
endmodule // tb
